/* File: design/asip_port.sv */
// Audio input port end: framing receiver, routing, masking and AHB controller.
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
module asip_port
	import asip_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	asip_if.port lnk,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic [SAMPLE_W-1:0] proc_left,
	output logic [SAMPLE_W-1:0] proc_right,
	output logic proc_valid
);
	typedef struct packed {
		logic [1:0] sync_pair;
		logic [1:0] stereo_rate_converter_pair;
		logic [1:0] three_stereo_rate_converter_pair;
		logic [1:0] stereo_rate_converter_line;
		logic [1:0] three_stereo_rate_converter_line;
		logic stereo_rate_converter_en;
		logic three_stereo_rate_converter_en;
		logic src2bc_en;
		logic master;
		asip_fmt_t fmt;
		asip_width_t width;
		logic [1:0] rx_line;
		logic bclk_d;
		logic ws_d;
		logic [4:0] bitn;
		logic [SAMPLE_W-1:0] sh;
		logic [SAMPLE_W-1:0] left;
		logic [SAMPLE_W-1:0] right;
		logic valid;
		logic mbclk;
		logic mws;
		logic [4:0] mbit;
		logic ph_wr;
		logic ph_rd;
		logic [7:0] ph_addr;
		logic [31:0] rdata;
		logic [7:0] frames;
	} asip_port_st_t;
	asip_port_st_t s_r, s_nxt;
	logic bclk, ws, sd, rise, left_slot, in_win, masked;
	logic [4:0] wbits, first;
	logic [SAMPLE_W-1:0] packed_s;
	always_comb begin
		s_nxt = s_r;
		s_nxt.valid = 1'b0;
		in_win = 1'b0;
		packed_s = '0;
		left_slot = 1'b0;
		case (s_r.width)
			W20: wbits = W20_BITS;
			W16: wbits = W16_BITS;
			default: wbits = W24_BITS;
		endcase
		case (s_r.fmt)
			FMT_I2S: first = MSB_POS_I2S;
			FMT_LJ: first = MSB_POS_LJ;
			default: first = 5'(SLOT_BITS) - wbits;
		endcase
		// Synchronous port follows its selected pair.
		bclk = lnk.bit_clock[s_r.sync_pair];
		ws = lnk.word_select[s_r.sync_pair];
		// Line feeding a converter is masked.
		masked = (s_r.stereo_rate_converter_en && s_r.stereo_rate_converter_line == s_r.rx_line) || (s_r.three_stereo_rate_converter_en && s_r.three_stereo_rate_converter_line == s_r.rx_line);
		sd = masked ? 1'b0 : lnk.serial_data[s_r.rx_line];
		// Framing follows the pair's own edges, so any slower rate is taken.
		s_nxt.bclk_d = bclk;
		rise = bclk && !s_r.bclk_d;
		// Sample data and word select on rising edge.
		if (rise) begin
			s_nxt.ws_d = ws;
			if (ws != s_r.ws_d) begin
				s_nxt.bitn = '0;
			end else begin
				s_nxt.bitn = s_r.bitn + 5'h01;
			end
			// Six-bit sums keep the right-justified window end of 32 from wrapping to zero.
			in_win = {1'b0, s_nxt.bitn} >= {1'b0, first} &&
				{1'b0, s_nxt.bitn} < {1'b0, first} + {1'b0, wbits};
			// Bits outside the width are ignored.
			if (in_win) begin
				s_nxt.sh = {s_r.sh[SAMPLE_W-2:0], sd};
			end
			if (s_nxt.bitn == first + wbits - 5'h01) begin
				// Missing low bits filled with zero.
				packed_s = s_nxt.sh << (5'(SAMPLE_W) - wbits);
				left_slot = (s_r.fmt == FMT_I2S) ? !ws : ws;
				if (left_slot) begin
					s_nxt.left = packed_s;
				end else begin
					s_nxt.right = packed_s;
					s_nxt.valid = 1'b1;
					s_nxt.frames = s_r.frames + 8'h01;
				end
			end
		end
		if (s_r.master) begin
			s_nxt.mbclk = ~s_r.mbclk;
			if (s_r.mbclk) begin
				s_nxt.mbit = s_r.mbit + 5'h01;
				if (s_r.mbit == SLOT_LAST) begin
					s_nxt.mws = ~s_r.mws;
				end
			end
		end
		// AHB slave: zero-wait answer; data phase write.
		s_nxt.ph_wr = hsel && htrans == HTRANS_NONSEQ && hwrite;
		s_nxt.ph_rd = hsel && htrans == HTRANS_NONSEQ && !hwrite;
		s_nxt.ph_addr = haddr;
		if (s_r.ph_wr) begin
			if (s_r.ph_addr == REG_CTRL) begin
				// Software picks framing and sample width.
				s_nxt.fmt = asip_fmt_t'(hwdata[1:0]);
				s_nxt.width = asip_width_t'(hwdata[3:2]);
				s_nxt.master = hwdata[4];
				// Bit for converter outputs b and c; src2bc_en is only stored and read back.
				s_nxt.src2bc_en = hwdata[5];
				s_nxt.stereo_rate_converter_en = hwdata[6];
				s_nxt.three_stereo_rate_converter_en = hwdata[7];
			end else if (s_r.ph_addr == REG_ROUTE) begin
				s_nxt.sync_pair = hwdata[1:0];
				s_nxt.stereo_rate_converter_pair = hwdata[3:2];
				s_nxt.three_stereo_rate_converter_pair = hwdata[5:4];
				s_nxt.stereo_rate_converter_line = hwdata[7:6];
				s_nxt.three_stereo_rate_converter_line = hwdata[9:8];
				s_nxt.rx_line = hwdata[11:10];
			end
		end
		if (s_nxt.ph_rd) begin
			if (haddr == REG_CTRL) begin
				s_nxt.rdata = {24'h0, s_r.three_stereo_rate_converter_en, s_r.stereo_rate_converter_en, s_r.src2bc_en, s_r.master, s_r.width, s_r.fmt};
			end else if (haddr == REG_ROUTE) begin
				s_nxt.rdata = {20'h0, s_r.rx_line, s_r.three_stereo_rate_converter_line, s_r.stereo_rate_converter_line, s_r.three_stereo_rate_converter_pair,
					s_r.stereo_rate_converter_pair, s_r.sync_pair};
			end else if (haddr == REG_LEFT) begin
				s_nxt.rdata = {8'h0, s_r.left};
			end else if (haddr == REG_RIGHT) begin
				s_nxt.rdata = {8'h0, s_r.right};
			end else if (haddr == REG_STAT) begin
				s_nxt.rdata = {24'h0, s_r.frames};
			end else begin
				s_nxt.rdata = 32'h0;
			end
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '0;
			s_r.sync_pair <= PAIR_ONE;
			s_r.stereo_rate_converter_pair <= PAIR_ZERO;
			s_r.three_stereo_rate_converter_pair <= PAIR_TWO;
			s_r.three_stereo_rate_converter_line <= LINE_TWO;
			// I2S framing and widest samples after reset.
			s_r.fmt <= FMT_I2S;
			s_r.width <= W24;
		end else begin
			s_r <= s_nxt;
		end
	end
	// Processor inputs; output a always present.
	assign proc_left = s_r.left;
	assign proc_right = s_r.right;
	assign proc_valid = s_r.valid;
	assign hrdata = s_r.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign lnk.clock_oe = s_r.master ? (3'h1 << s_r.sync_pair) : 3'h0;
	assign lnk.bit_clock_i = {3{s_r.mbclk}};
	assign lnk.word_select_i = {3{s_r.mws}};
	assign lnk.serial_out = s_r.left[SAMPLE_W-1];
endmodule

/* File: shared/asip_pkg.sv */
// Shared constants and types for the serial audio input port and its source.
// Summary of operation
// - Synchronous port picks clock pair; pair one default.
// - Slave mode: source drives bit clock, word select.
// - Master mode: port generates clocks from master clock.
// - Converters accept any rate five to fifty kHz; no converter logic here, SRC_MIN_HZ and SRC_MAX_HZ go unused.
// - Converter output delivered on processor timing; no converter output exists here.
// - Stereo converter: any line, any pair, pair zero.
// - Three-stereo converter: any line, pair two default.
// - Converter source lines masked from synchronous inputs.
// - Output a always feeds; b, c muxed; only output a (proc_left, proc_right) is built here.
// - Muxes default to lines; register enables converter; no muxes here, src2bc_en is only read back.
// - Serial output timed by synchronous port pair.
// - Word select toggles once per sample half.
// - Bit clock is sixty-four times sample rate.
// - Format selectable; I2S after reset.
// - Width selectable 16/20/24; 24 after reset.
// - I2S: MSB in second bit period.
// - I2S: falling edge left, rising edge right.
// - Left-justified: MSB in first bit period.
// - Left-justified: falling right, rising left.
// - Right-justified: LSB last before edge.
package asip_pkg;
	localparam int SLOT_BITS = 32;
	localparam int SAMPLE_W = 24;
	localparam int BIT_CNT_W = 5;
	localparam logic [4:0] SLOT_LAST = 5'h1F;
	localparam logic [4:0] MSB_POS_I2S = 5'h01;
	localparam logic [4:0] MSB_POS_LJ = 5'h00;
	localparam int N_LINES = 4;
	localparam int N_PAIRS = 3;
	localparam logic [1:0] PAIR_ZERO = 2'h0;
	localparam logic [1:0] PAIR_ONE = 2'h1;
	localparam logic [1:0] PAIR_TWO = 2'h2;
	localparam logic [1:0] LINE_TWO = 2'h2;
	localparam logic [1:0] LINE_THREE = 2'h3;
	// Master bit clock: one half-period every MCLK_HALF cycles of hclk.
	localparam logic [3:0] MCLK_HALF = 4'h1;
	typedef enum logic [1:0] {FMT_I2S, FMT_LJ, FMT_RJ} asip_fmt_t;
	typedef enum logic [1:0] {W24, W20, W16} asip_width_t;
	localparam logic [4:0] W24_BITS = 5'h18;
	localparam logic [4:0] W20_BITS = 5'h14;
	localparam logic [4:0] W16_BITS = 5'h10;
	localparam int SRC_MIN_HZ = 5000;
	localparam int SRC_MAX_HZ = 50000;
	// AHB register map of the controller.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ROUTE = 8'h04;
	localparam logic [7:0] REG_LEFT = 8'h08;
	localparam logic [7:0] REG_RIGHT = 8'h0C;
	localparam logic [7:0] REG_STAT = 8'h10;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_IDLE = 2'h0;
endpackage

/* File: shared/asip_if.sv */
// Interface joining the audio source and the audio input port.
`timescale 1ns/100ps
interface asip_if;
	logic [2:0] bit_clock_o;
	logic [2:0] word_select_o;
	logic [2:0] clock_oe;
	logic [2:0] bit_clock_i;
	logic [2:0] word_select_i;
	logic [3:0] serial_data;
	logic serial_out;
	// Each pair's wire is the port's drive when it masters, else the source's.
	logic [2:0] bit_clock;
	logic [2:0] word_select;
	assign bit_clock = (clock_oe & bit_clock_i) | (~clock_oe & bit_clock_o);
	assign word_select = (clock_oe & word_select_i) | (~clock_oe & word_select_o);
	modport source (output bit_clock_o, output word_select_o, output serial_data, input clock_oe,
		input serial_out);
	modport port (input bit_clock, input word_select, input serial_data, output clock_oe,
		output bit_clock_i, output word_select_i, output serial_out);
endinterface

/* File: design/asip_source.sv */
// Audio source end: generates clock pairs and serialises samples on four lines.
`timescale 1ns/100ps
module asip_source
	import asip_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	asip_if.source lnk,
	input wire logic run,
	input wire asip_pkg::asip_fmt_t fmt,
	input wire asip_pkg::asip_width_t width,
	input wire logic [SAMPLE_W-1:0] left_sample,
	input wire logic [SAMPLE_W-1:0] right_sample,
	input wire logic [1:0] drive_pair,
	output logic sample_taken
);
	typedef struct packed {
		logic bclk;
		logic ws;
		logic [4:0] bitn;
		logic [SAMPLE_W-1:0] sh;
		logic sd;
		logic taken;
		logic [1:0] pair;
	} asip_src_st_t;
	asip_src_st_t s_r, s_nxt;
	logic [4:0] wbits;
	logic [4:0] first;
	logic start_left;
	always_comb begin
		case (width)
			W20: wbits = W20_BITS;
			W16: wbits = W16_BITS;
			default: wbits = W24_BITS;
		endcase
		case (fmt)
			FMT_I2S: first = MSB_POS_I2S;
			FMT_LJ: first = MSB_POS_LJ;
			default: first = 5'(SLOT_BITS) - wbits;
		endcase
		s_nxt = s_r;
		s_nxt.taken = 1'b0;
		start_left = 1'b0;
		if (run) begin
			s_nxt.bclk = ~s_r.bclk;
			if (s_r.bclk) begin
				// Falling edge: advance slot bit and drive data.
				s_nxt.bitn = s_r.bitn + 5'h01;
				if (s_r.bitn == SLOT_LAST) begin
					s_nxt.ws = ~s_r.ws;
				end
				start_left = (fmt == FMT_I2S) ? s_r.ws : ~s_r.ws;
				if (s_r.bitn == SLOT_LAST) begin
					s_nxt.sh = start_left ? left_sample : right_sample;
					s_nxt.taken = start_left;
				end
				if (s_r.bitn == SLOT_LAST && s_r.ws) begin
					// Pairs swap only where word select falls, so neither pair shows a stray edge.
					s_nxt.pair = drive_pair;
				end
				// Six-bit sums keep the right-justified window end of 32 from wrapping to zero.
				if ({1'b0, s_nxt.bitn} >= {1'b0, first} &&
					{1'b0, s_nxt.bitn} < {1'b0, first} + {1'b0, wbits}) begin
					s_nxt.sd = s_nxt.sh[SAMPLE_W-1];
					s_nxt.sh = {s_nxt.sh[SAMPLE_W-2:0], 1'b0};
				end else begin
					s_nxt.sd = 1'b0;
				end
			end
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
	// Source drives its chosen pair; the other pairs stand still at zero.
	always_comb begin
		for (int i = 0; i < N_PAIRS; i++) begin
			lnk.bit_clock_o[i] = (s_r.pair == 2'(i)) ? s_r.bclk : 1'b0;
			lnk.word_select_o[i] = (s_r.pair == 2'(i)) ? s_r.ws : 1'b0;
		end
		for (int j = 0; j < N_LINES; j++) begin
			lnk.serial_data[j] = s_r.sd;
		end
	end
	assign sample_taken = s_r.taken;
endmodule

/* File: verification/asip_sva.sv */
// Concurrent checks on the serial audio link between source and port.
`timescale 1ns/100ps
module asip_sva (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [2:0] bit_clock,
	input wire logic [2:0] word_select,
	input wire logic [3:0] serial_data,
	input wire logic [2:0] clock_oe,
	input wire logic serial_out
);
	typedef struct packed {logic [6:0] cyc; logic [5:0] rises; logic seen; logic bclk; logic ws;} asip_mon_t;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	slave_after_reset_a: assert property ($rose(hresetn) |-> clock_oe == 3'h0)
		else $error("port drives clocks after reset");
	data_on_fall_a: assert property ($changed(serial_data) |-> |($past(bit_clock) & ~bit_clock))
		else $error("serial data moved off a falling bit clock");
	out_on_fall_a: assert property (clock_oe == 3'h0 && $changed(serial_out) |-> |($past(bit_clock) & ~bit_clock))
		else $error("serial output moved off a falling bit clock");
	for (genvar g = 0; g < 3; g++) begin : pair_g
		asip_mon_t st_r;
		asip_mon_t st_nxt;
		logic chg;
		logic rise;
		assign chg = word_select[g] != st_r.ws;
		assign rise = bit_clock[g] & ~st_r.bclk;
		// A pair whose bit clock stands still drops its history, so a restarted frame is not judged.
		always_comb begin
			st_nxt = st_r;
			st_nxt.bclk = bit_clock[g];
			st_nxt.ws = word_select[g];
			st_nxt.cyc = chg ? 7'h00 : st_r.cyc + 7'h01;
			st_nxt.rises = chg ? 6'h00 : st_r.rises + {5'h00, rise};
			if (bit_clock[g] == st_r.bclk) begin
				st_nxt.seen = 1'b0;
			end else if (chg) begin
				st_nxt.seen = 1'b1;
			end
		end
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				st_r <= '0;
			end else begin
				st_r <= st_nxt;
			end
		end
		sequence slot_hold_s;
			$stable(word_select[g])[*8];
		endsequence
		slot_length_a: assert property (chg && st_r.seen |-> st_r.cyc == 7'h3F)
			else $error("slot length is not 64 clock cycles");
		slot_bits_a: assert property (chg && st_r.seen |-> st_r.rises == 6'h20)
			else $error("slot does not hold 32 bit periods");
		select_on_fall_a: assert property ($changed(word_select[g]) |-> $fell(bit_clock[g]))
			else $error("word select moved off a falling bit clock");
		slot_hold_a: assert property (chg |=> slot_hold_s)
			else $error("word select toggled inside a slot");
		clock_half_a: assert property ($rose(bit_clock[g]) |=> $fell(bit_clock[g]))
			else $error("bit clock high longer than one cycle");
	end
endmodule

/* File: verification/audio_serial_input_port_tb.sv */
// Self-checking bench joining the audio source and the audio input port.
`timescale 1ns/100ps
module audio_serial_input_port_tb;
	import asip_pkg::*;
	logic hclk, hresetn, hsel, hwrite, run, proc_valid, hreadyout;
	logic [7:0] haddr;
	logic [1:0] htrans, drive_pair;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, slot, q;
	logic [23:0] left_s, right_s, proc_left, proc_right, m, got;
	asip_fmt_t src_fmt;
	asip_width_t src_width;
	int n_errors = 0;
	int checks = 0;
	int cycles = 0;
	int bits;
	asip_if lnk_if ();
	asip_source asip_source_i (.hclk(hclk), .hresetn(hresetn), .lnk(lnk_if), .run(run), .fmt(src_fmt),
		.width(src_width), .left_sample(left_s), .right_sample(right_s), .drive_pair(drive_pair), .sample_taken());
	asip_port asip_port_i (.hclk(hclk), .hresetn(hresetn), .lnk(lnk_if), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(), .proc_left(proc_left), .proc_right(proc_right), .proc_valid(proc_valid));
	asip_sva asip_sva_i (.hclk(hclk), .hresetn(hresetn), .bit_clock(lnk_if.bit_clock),
		.word_select(lnk_if.word_select), .serial_data(lnk_if.serial_data), .clock_oe(lnk_if.clock_oe),
		.serial_out(lnk_if.serial_out));
	always #50 hclk = ~hclk;
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// The whole sequence needs under 10000 cycles; a stalled handshake ends the run here.
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			n_errors++;
			stop_test();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		haddr <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= HTRANS_IDLE;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		bus(a, 1'b0, 32'h00000000);
		check(what, q, exp);
	endtask
	task automatic frames(input int n);
		repeat (n) begin
			do @(posedge hclk); while (proc_valid !== 1'b1);
		end
	endtask
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b1;
		hwrite = 1'b0;
		haddr = 8'h00;
		htrans = HTRANS_IDLE;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		run = 1'b1;
		drive_pair = PAIR_ONE;
		src_fmt = FMT_I2S;
		src_width = W24;
		left_s = 24'hC3A5E7;
		right_s = 24'h5A3C81;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rd(REG_CTRL, 32'h00000000, "ctrl reset");
		rd(REG_ROUTE, 32'h00000221, "route reset");
		bus(8'h14, 1'b1, 32'hFFFFFFFF);
		rd(8'h14, 32'h00000000, "unmapped");
		$display("test defaults done");
		for (int f = 0; f < 3; f++) begin
			for (int w = 0; w < 3; w++) begin
				src_fmt <= asip_fmt_t'(f[1:0]);
				src_width <= asip_width_t'(w[1:0]);
				bits = 24 - 4 * w;
				m = 24'hFFFFFF << (24 - bits);
				bus(REG_CTRL, 1'b1, {28'h0000000, w[1:0], f[1:0]});
				// The frame cut by the change may pulse twice; the third pulse is clean.
				frames(3);
				check("left sample", {8'h00, proc_left}, {8'h00, left_s & m});
				check("right sample", {8'h00, proc_right}, {8'h00, right_s & m});
				rd(REG_LEFT, {8'h00, left_s & m}, "left register");
				if (f == 0) begin
					@(negedge lnk_if.word_select[1]);
				end else begin
					@(posedge lnk_if.word_select[1]);
				end
				repeat (32) begin
					@(posedge lnk_if.bit_clock[1]);
					slot = {slot[30:0], lnk_if.serial_data[0]};
				end
				got = (f == 0) ? slot[30:7] : (f == 1) ? slot[31:8] : slot[23:0] << (24 - bits);
				check("wire left slot", {8'h00, got & m}, {8'h00, left_s & m});
			end
		end
		$display("test formats done");
		bus(REG_ROUTE, 1'b1, 32'h000006E6);
		rd(REG_ROUTE, 32'h000006E6, "route write");
		drive_pair <= PAIR_TWO;
		src_fmt <= FMT_I2S;
		src_width <= W24;
		bus(REG_CTRL, 1'b1, 32'h00000000);
		frames(3);
		check("pair two sample", {8'h00, proc_left}, {8'h00, left_s});
		$display("test pair done");
		drive_pair <= PAIR_ONE;
		bus(REG_ROUTE, 1'b1, 32'h00000461);
		bus(REG_CTRL, 1'b1, 32'h00000040);
		frames(3);
		check("masked line", {8'h00, proc_left}, 32'h00000000);
		$display("test mask done");
		drive_pair <= PAIR_ZERO;
		// Pair one must stand idle before the port takes it over, or its wires jump.
		@(negedge lnk_if.word_select[1]);
		bus(REG_ROUTE, 1'b1, 32'h00000021);
		bus(REG_CTRL, 1'b1, 32'h00000010);
		// Frames only arrive if the port's own clocks frame pair one.
		frames(3);
		check("master enable", {29'h00000000, lnk_if.clock_oe}, 32'h00000002);
		bus(REG_CTRL, 1'b1, 32'h00000000);
		$display("test master done");
		stop_test();
	end
endmodule
